// >>> rtl/rail_strobe_assignment.sv
// Strobe slot selector registers and the slot-stepping rail enable sequencer
// Function
// - Buck three selector bits 6-4; code 0 keeps the rail out of sequencing.
// - Codes 1 to 7 enable the rail at the strobe slot of that number.
// - Linear regulator one selector bits 3-0; codes 8 and 9 mean not sequenced.
// - Code 14 means slot fourteen; code 15 slot fifteen with the supply path.
// - Register 0x1B bits 7-4 hold linear regulator two, same code meanings.
// - Switch one selector in 0x1B bits 2-0; bit 3 reserved, reads zero.
// - Register 0x1C bits 6-4 hold switch two selector, reset to slot four.
// - Register 0x1C bits 3-0 are read-only zero; writes ignored.
// - Selector writes are ignored unless the unlock step just completed.
// - Reset contents of 0x1A and 0x1B depend on a variant parameter.
// - Normal power-down turns rails off in reverse slot order.
// - Instant shutdown turns all sequenced rails off at once.
`timescale 1ns/1ps
module rail_strobe_assignment #(
  parameter int unsigned VARIANT = 0
) (
  input  wire logic       ref_clk,
  input  wire logic       srst,
  input  wire logic [7:0] reg_addr,
  input  wire logic       reg_wr_en,
  input  wire logic [7:0] reg_wr_data,
  output logic      [7:0] reg_rd_data,
  input  wire logic       write_unlocked,
  input  wire logic       power_up_trigger,
  input  wire logic       power_down_trigger,
  input  wire logic       instant_shutdown_select,
  input  wire logic       power_request_pin,
  input  wire logic       slot_step,
  output logic      [4:0] rail_en,
  output logic            system_supply_path,
  output logic      [3:0] current_slot,
  output logic            seq_busy
);
  logic [7:0]             reg_a_r;
  logic [7:0]             reg_b_r;
  logic [7:0]             reg_c_r;
  logic [7:0]             rd_data_r;
  logic [4:0]             rail_on_r;
  logic                   sys_on_r;
  logic [3:0]             slot_r;
  logic                   pin_prev_r;
  logic                   down_req;
  logic [4:0]             controlled;
  strobe_pkg::seq_state_t state_r;
  slot_map_if             map ();

  slot_decode u_decode (
    .map (map.decoder)
  );

  assign map.code[strobe_pkg::R_BUCK3]   = {1'b0, reg_a_r[strobe_pkg::BUCK3_LSB +: 3]};
  assign map.code[strobe_pkg::R_LINREG1] = reg_a_r[strobe_pkg::LINREG1_LSB +: 4];
  assign map.code[strobe_pkg::R_LINREG2] = reg_b_r[strobe_pkg::LINREG2_LSB +: 4];
  assign map.code[strobe_pkg::R_SWITCH1] = {1'b0, reg_b_r[strobe_pkg::SWITCH1_LSB +: 3]};
  assign map.code[strobe_pkg::R_SWITCH2] = {1'b0, reg_c_r[strobe_pkg::SWITCH2_LSB +: 3]};

  for (genvar i = 0; i < strobe_pkg::NUM_RAILS; i++) begin : g_ctl
    assign controlled[i] = (map.slot[i] != strobe_pkg::SLOT_NONE);
  end

  // Selector registers; reserved bits masked off so they never store
  always_ff @(posedge ref_clk) begin
    if (srst) begin
      reg_a_r <= strobe_pkg::RST_A[VARIANT];
      reg_b_r <= strobe_pkg::RST_B[VARIANT];
      reg_c_r <= strobe_pkg::RST_C;
    end else if (reg_wr_en && write_unlocked) begin
      // Reserved codes are stored as written; they decode to no slot
      case (reg_addr)
        strobe_pkg::ADDR_A: reg_a_r <= reg_wr_data & strobe_pkg::MASK_A;
        strobe_pkg::ADDR_B: reg_b_r <= reg_wr_data & strobe_pkg::MASK_B;
        strobe_pkg::ADDR_C: reg_c_r <= reg_wr_data & strobe_pkg::MASK_C;
        default: ;
      endcase
    end
  end

  // Read data one clock after the address, unmapped reads zero
  always_ff @(posedge ref_clk) begin
    if (srst) begin
      rd_data_r <= 8'h00;
    end else begin
      case (reg_addr)
        strobe_pkg::ADDR_A: rd_data_r <= reg_a_r;
        strobe_pkg::ADDR_B: rd_data_r <= reg_b_r;
        strobe_pkg::ADDR_C: rd_data_r <= reg_c_r;
        default:            rd_data_r <= 8'h00;
      endcase
    end
  end

  // Falling power request acts like a down trigger
  always_ff @(posedge ref_clk) begin
    if (srst) begin
      pin_prev_r <= 1'b0;
    end else begin
      pin_prev_r <= power_request_pin;
    end
  end

  // Trigger bits are single pulses here, so self-clearing is inherent
  assign down_req = power_down_trigger || (pin_prev_r && !power_request_pin);

  // Slot stepping; a down request pre-empts a power-up in progress
  always_ff @(posedge ref_clk) begin
    if (srst) begin
      state_r <= strobe_pkg::ST_IDLE;
      slot_r  <= strobe_pkg::SLOT_NONE;
    end else if (down_req && instant_shutdown_select) begin
      state_r <= strobe_pkg::ST_IDLE;
      slot_r  <= strobe_pkg::SLOT_NONE;
    end else if (down_req) begin
      state_r <= strobe_pkg::ST_DOWN;
      if (state_r != strobe_pkg::ST_UP) begin
        slot_r <= strobe_pkg::SLOT_LAST;
      end
    end else begin
      case (state_r)
        strobe_pkg::ST_IDLE: begin
          if (power_up_trigger) begin
            state_r <= strobe_pkg::ST_UP;
            slot_r  <= strobe_pkg::SLOT_FIRST;
          end
        end
        strobe_pkg::ST_UP: begin
          if (slot_step) begin
            if (slot_r == strobe_pkg::SLOT_LAST) begin
              state_r <= strobe_pkg::ST_IDLE;
              slot_r  <= strobe_pkg::SLOT_NONE;
            end else begin
              slot_r <= slot_r + 4'h1;
            end
          end
        end
        strobe_pkg::ST_DOWN: begin
          if (slot_step) begin
            if (slot_r == strobe_pkg::SLOT_FIRST) begin
              state_r <= strobe_pkg::ST_IDLE;
              slot_r  <= strobe_pkg::SLOT_NONE;
            end else begin
              slot_r <= slot_r - 4'h1;
            end
          end
        end
        default: begin
          state_r <= strobe_pkg::ST_IDLE;
          slot_r  <= strobe_pkg::SLOT_NONE;
        end
      endcase
    end
  end

  // Rail enables; rails outside sequencer control keep their state
  for (genvar i = 0; i < strobe_pkg::NUM_RAILS; i++) begin : g_rail
    always_ff @(posedge ref_clk) begin
      if (srst) begin
        rail_on_r[i] <= 1'b0;
      end else if (down_req && instant_shutdown_select && controlled[i]) begin
        rail_on_r[i] <= 1'b0;
      end else if (controlled[i] && map.slot[i] == slot_r) begin
        if (state_r == strobe_pkg::ST_UP) begin
          rail_on_r[i] <= 1'b1;
        end else if (state_r == strobe_pkg::ST_DOWN) begin
          rail_on_r[i] <= 1'b0;
        end
      end
    end
  end

  // System supply path follows slot fifteen
  always_ff @(posedge ref_clk) begin
    if (srst) begin
      sys_on_r <= 1'b0;
    end else if (down_req && instant_shutdown_select) begin
      sys_on_r <= 1'b0;
    end else if (slot_r == strobe_pkg::SLOT_SYS && state_r == strobe_pkg::ST_UP) begin
      sys_on_r <= 1'b1;
    end else if (slot_r == strobe_pkg::SLOT_SYS && state_r == strobe_pkg::ST_DOWN) begin
      sys_on_r <= 1'b0;
    end
  end

  assign reg_rd_data        = rd_data_r;
  assign rail_en            = rail_on_r;
  assign system_supply_path = sys_on_r;
  assign current_slot       = slot_r;
  assign seq_busy           = (state_r != strobe_pkg::ST_IDLE);

  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (srst);

  sequence up_start_s;
    state_r == strobe_pkg::ST_IDLE && power_up_trigger && !down_req;
  endsequence
  sequence at_slot_one_s;
    state_r == strobe_pkg::ST_UP && slot_r == strobe_pkg::SLOT_FIRST;
  endsequence

  locked_write_a: assert property (reg_wr_en && !write_unlocked |=>
    reg_a_r == $past(reg_a_r) && reg_b_r == $past(reg_b_r) && reg_c_r == $past(reg_c_r))
    else $error("selector changed by a locked write");
  reserved_b_a: assert property ($past(reg_addr) == strobe_pkg::ADDR_B |-> !reg_rd_data[3])
    else $error("reserved bit of 0x1b read as one");
  reserved_c_a: assert property ($past(reg_addr) == strobe_pkg::ADDR_C |-> reg_rd_data[3:0] == 4'h0)
    else $error("reserved bits of 0x1c read nonzero");
  buck3_free_a: assert property (reg_a_r[6:4] == 3'h0 && $stable(reg_a_r) |=> $stable(rail_en[0]))
    else $error("unsequenced buck three rail changed");
  linreg_none_a: assert property (map.code[1] inside {4'h8, 4'h9} |-> map.slot[1] == 4'h0)
    else $error("codes 8 or 9 decoded to a slot");
  same_code_a: assert property (map.code[2] == map.code[1] |-> map.slot[2] == map.slot[1])
    else $error("linear regulators decode differently");
  narrow_code_a: assert property (map.code[3] != 4'h0 |-> map.slot[3] == map.code[3])
    else $error("three-bit code decoded wrong");
  up_entry_a: assert property (up_start_s |=> at_slot_one_s)
    else $error("power-up did not begin at slot one");
  up_enable_a: assert property (state_r == strobe_pkg::ST_UP && !down_req && controlled[2] &&
    map.slot[2] == slot_r |=> rail_en[2])
    else $error("rail not enabled at its slot");
  down_order_a: assert property (state_r == strobe_pkg::ST_DOWN && !down_req && controlled[1] &&
    map.slot[1] == slot_r |=> !rail_en[1])
    else $error("rail not disabled at its slot going down");
  instant_off_a: assert property (down_req && instant_shutdown_select |=>
    (rail_en & $past(controlled)) == 5'h00 && !system_supply_path && !seq_busy)
    else $error("instant shutdown left a rail on");
  supply_path_a: assert property (state_r == strobe_pkg::ST_UP && slot_r == strobe_pkg::SLOT_SYS
    && !down_req |=> system_supply_path)
    else $error("supply path not raised at slot fifteen");
endmodule // rail_strobe_assignment

// >>> rtl/slot_decode.sv
// Maps each rail's selector code to a strobe slot number, zero meaning none
`timescale 1ns/1ps
module slot_decode (
  slot_map_if.decoder map
);
  for (genvar i = 0; i < strobe_pkg::NUM_RAILS; i++) begin : g_rail
    if (strobe_pkg::WIDE_RAILS[i]) begin : g_wide
      always_comb begin
        if (map.code[i] <= strobe_pkg::CODE_MAX_LO) begin
          map.slot[i] = map.code[i];
        end else if (map.code[i] == strobe_pkg::CODE_S14 || map.code[i] == strobe_pkg::CODE_S15) begin
          map.slot[i] = map.code[i];
        end else begin
          // 8, 9 and the reserved codes leave the rail alone
          map.slot[i] = strobe_pkg::SLOT_NONE;
        end
      end
    end else begin : g_narrow
      // Three-bit field: 6 and 7 taken as their own slots
      always_comb begin
        map.slot[i] = {1'b0, map.code[i][2:0]};
      end
    end
  end
endmodule // slot_decode

// >>> rtl/slot_map_if.sv
// Selector codes in, decoded strobe slots out
`timescale 1ns/1ps
interface slot_map_if;
  logic [4:0][3:0] code;
  logic [4:0][3:0] slot;
  modport decoder (input code, output slot);
  modport user    (output code, input slot);
endinterface

// >>> rtl/strobe_pkg.sv
// Constants for the rail strobe assignment block
package strobe_pkg;
  localparam logic [7:0] ADDR_A      = 8'h1a;
  localparam logic [7:0] ADDR_B      = 8'h1b;
  localparam logic [7:0] ADDR_C      = 8'h1c;
  // Writable bits; reserved bits are never stored and read as zero
  localparam logic [7:0] MASK_A      = 8'h7f;
  localparam logic [7:0] MASK_B      = 8'hf7;
  localparam logic [7:0] MASK_C      = 8'h70;
  localparam logic [7:0] RST_C       = 8'h40;
  // Per factory variant, index 0..3
  localparam logic [7:0] RST_A [4]   = '{8'h3b, 8'h5f, 8'h5f, 8'h5f};
  localparam logic [7:0] RST_B [4]   = '{8'h21, 8'h23, 8'h32, 8'h32};
  // Field positions (low bit of each field)
  localparam int         BUCK3_LSB   = 4;
  localparam int         LINREG1_LSB = 0;
  localparam int         LINREG2_LSB = 4;
  localparam int         SWITCH1_LSB = 0;
  localparam int         SWITCH2_LSB = 4;
  // Rail order on the enable vector
  localparam int         NUM_RAILS   = 5;
  localparam int         R_BUCK3     = 0;
  localparam int         R_LINREG1   = 1;
  localparam int         R_LINREG2   = 2;
  localparam int         R_SWITCH1   = 3;
  localparam int         R_SWITCH2   = 4;
  localparam logic [4:0] WIDE_RAILS  = 5'h06;
  // Code meanings
  localparam logic [3:0] SLOT_NONE   = 4'h0;
  localparam logic [3:0] SLOT_FIRST  = 4'h1;
  localparam logic [3:0] SLOT_LAST   = 4'hf;
  localparam logic [3:0] CODE_MAX_LO = 4'h7;
  localparam logic [3:0] CODE_S14    = 4'he;
  localparam logic [3:0] CODE_S15    = 4'hf;
  localparam logic [3:0] SLOT_SYS    = 4'hf;
  typedef enum logic [1:0] {ST_IDLE, ST_UP, ST_DOWN} seq_state_t;
endpackage

// >>> verif/rail_strobe_assignment_tb.sv
// Self-checking bench for the strobe selector registers and slot sequencer
`timescale 1ns/1ps
module rail_strobe_assignment_tb;
  logic       ref_clk;
  logic       srst;
  logic [7:0] reg_addr;
  logic       reg_wr_en;
  logic [7:0] reg_wr_data;
  logic [7:0] reg_rd_data;
  logic       write_unlocked;
  logic       power_up_trigger;
  logic       power_down_trigger;
  logic       instant_shutdown_select;
  logic       power_request_pin;
  logic       slot_step;
  logic [4:0] rail_en;
  logic       system_supply_path;
  logic [3:0] current_slot;
  logic       seq_busy;
  int         num_errors;
  int         n_compared;
  logic [3:0] cd [5];
  logic [7:0] rdv;
  logic [7:0] a;
  logic [7:0] d;

  rail_strobe_assignment #(.VARIANT(0)) rail_strobe_assignment_i (
    .ref_clk(ref_clk), .srst(srst), .reg_addr(reg_addr), .reg_wr_en(reg_wr_en), .reg_wr_data(reg_wr_data),
    .reg_rd_data(reg_rd_data), .write_unlocked(write_unlocked), .power_up_trigger(power_up_trigger),
    .power_down_trigger(power_down_trigger), .instant_shutdown_select(instant_shutdown_select),
    .power_request_pin(power_request_pin), .slot_step(slot_step), .rail_en(rail_en),
    .system_supply_path(system_supply_path), .current_slot(current_slot), .seq_busy(seq_busy));

  initial begin
    ref_clk = 1'b0;
    forever #12.5 ref_clk = ~ref_clk;
  end

  task automatic finish_test();
    $display("Comparisons %0d, mismatches %0d", n_compared, num_errors);
    if (num_errors == 0 && n_compared > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask

  task automatic chk(input logic [7:0] got, input logic [7:0] exp, input string m);
    n_compared++;
    if (got !== exp) begin
      num_errors++;
      $display("wrong value at %0t: %s got %h expected %h", $time, m, got, exp);
    end
  endtask

  task automatic wr(input logic [7:0] ad, input logic [7:0] dt);
    @(negedge ref_clk) reg_addr = ad;
    reg_wr_data = dt;
    reg_wr_en = 1'b1;
    @(negedge ref_clk) reg_wr_en = 1'b0;
  endtask

  // Two edges after the address so a just-written value has landed
  task automatic rd(input logic [7:0] ad, output logic [7:0] dt);
    @(negedge ref_clk) reg_addr = ad;
    @(negedge ref_clk);
    @(negedge ref_clk) dt = reg_rd_data;
  endtask

  function automatic logic [3:0] dec4(logic [3:0] c);
    return (c == 4'h0 || (c >= 4'h8 && c <= 4'hd)) ? 4'h0 : c;
  endfunction

  function automatic logic [4:0] exp_on(int lo, int hi);
    logic [4:0] v;
    logic [3:0] sl;
    v = 5'h00;
    for (int r = 0; r < strobe_pkg::NUM_RAILS; r++) begin
      sl = strobe_pkg::WIDE_RAILS[r] ? dec4(cd[r]) : {1'b0, cd[r][2:0]};
      v[r] = (sl != 4'h0) && (sl >= lo) && (sl <= hi);
    end
    return v;
  endfunction

  task automatic cfg(input logic [3:0] b3, input logic [3:0] l1, input logic [3:0] l2,
                     input logic [3:0] s1, input logic [3:0] s2);
    cd = '{b3, l1, l2, s1, s2};
    write_unlocked = 1'b1;
    wr(strobe_pkg::ADDR_A, {1'b0, b3[2:0], l1});
    wr(strobe_pkg::ADDR_B, {l2, 1'b0, s1[2:0]});
    wr(strobe_pkg::ADDR_C, {1'b0, s2[2:0], 4'h0});
    write_unlocked = 1'b0;
  endtask

  // Walks slots one up to top, or top down to one, one step pulse per slot
  task automatic walk(input bit dn, input int top);
    int         s;
    logic [4:0] ev;
    for (int k = 1; k <= top; k++) begin
      s = dn ? top + 1 - k : k;
      ev = dn ? exp_on(1, s - 1) : exp_on(1, s);
      @(negedge ref_clk);
      chk(8'(rail_en), 8'(ev), "rails");
      chk(8'(current_slot), 8'(s), "slot");
      slot_step = 1'b1;
      @(negedge ref_clk) slot_step = 1'b0;
    end
    chk(8'(seq_busy), 8'h00, "busy after walk");
    chk(8'(system_supply_path), 8'(top == 15 && !dn), "supply");
  endtask

  task automatic power_up();
    @(negedge ref_clk) power_up_trigger = 1'b1;
    @(negedge ref_clk) power_up_trigger = 1'b0;
    chk(8'(seq_busy), 8'h01, "busy up");
    walk(1'b0, 15);
  endtask

  initial begin
    {reg_addr, reg_wr_en, reg_wr_data, write_unlocked, slot_step} = '0;
    {power_up_trigger, power_down_trigger, instant_shutdown_select} = '0;
    power_request_pin = 1'b1;
    num_errors = 0;
    n_compared = 0;
    srst = 1'b1;
    void'($urandom(32'haa1ba939));
    repeat (16) @(negedge ref_clk);
    srst = 1'b0;
    rd(strobe_pkg::ADDR_A, rdv);
    chk(rdv, 8'h3b, "reset a");
    rd(strobe_pkg::ADDR_B, rdv);
    chk(rdv, 8'h21, "reset b");
    rd(strobe_pkg::ADDR_C, rdv);
    chk(rdv, 8'h40, "reset c");
    wr(strobe_pkg::ADDR_B, 8'hff);
    rd(strobe_pkg::ADDR_B, rdv);
    chk(rdv, 8'h21, "locked write");
    write_unlocked = 1'b1;
    wr(strobe_pkg::ADDR_B, 8'hff);
    rd(strobe_pkg::ADDR_B, rdv);
    chk(rdv, 8'hf7, "reserved b3");
    wr(strobe_pkg::ADDR_C, 8'hff);
    rd(strobe_pkg::ADDR_C, rdv);
    chk(rdv, 8'h70, "reserved c");
    wr(8'h1d, 8'hff);
    rd(8'h1d, rdv);
    chk(rdv, 8'h00, "unmapped");
    for (int i = 0; i < 8; i++) begin
      a = 8'h1a + 8'($urandom_range(0, 2));
      d = 8'($urandom);
      wr(a, d);
      rd(a, rdv);
      chk(rdv, d & (a == 8'h1a ? 8'h7f : a == 8'h1b ? 8'hf7 : 8'h70), "random write");
    end
    write_unlocked = 1'b0;
    for (int r = 0; r < 4; r++) begin
      if (r == 0) cfg(4'h7, 4'h8, 4'hf, 4'h6, 4'h0);
      else if (r == 1) cfg(4'h0, 4'h9, 4'he, 4'h1, 4'h5);
      else begin
        // Reserved four-bit codes are never written by software
        d = 8'($urandom_range(0, 11));
        a = 8'($urandom_range(0, 11));
        cfg(4'($urandom_range(0, 7)), d > 9 ? d[3:0] + 4'h4 : d[3:0], a > 9 ? a[3:0] + 4'h4 : a[3:0],
            4'($urandom_range(0, 7)), 4'($urandom_range(0, 7)));
      end
      power_up();
      @(negedge ref_clk) power_down_trigger = 1'b1;
      @(negedge ref_clk) power_down_trigger = 1'b0;
      walk(1'b1, 15);
    end
    // Pin falling mid power-up turns back from the current slot; a late up trigger is ignored
    cfg(4'h2, 4'h1, 4'h3, 4'h3, 4'h2);
    @(negedge ref_clk) power_up_trigger = 1'b1;
    @(negedge ref_clk) power_up_trigger = 1'b0;
    repeat (2) begin
      @(negedge ref_clk) slot_step = 1'b1;
      @(negedge ref_clk) slot_step = 1'b0;
    end
    @(negedge ref_clk) power_up_trigger = 1'b1;
    @(negedge ref_clk) power_up_trigger = 1'b0;
    chk(8'(current_slot), 8'h03, "up trigger while busy");
    chk(8'(rail_en), 8'(exp_on(1, 3)), "partial up");
    @(negedge ref_clk) power_request_pin = 1'b0;
    @(negedge ref_clk) power_request_pin = 1'b1;
    chk(8'({seq_busy, current_slot}), 8'h13, "down from mid up");
    walk(1'b1, 3);
    power_up();
    @(negedge ref_clk) instant_shutdown_select = 1'b1;
    power_request_pin = 1'b0;
    repeat (2) @(negedge ref_clk);
    chk(8'(rail_en), 8'h00, "instant rails");
    chk(8'({seq_busy, system_supply_path, current_slot}), 8'h00, "instant idle");
    finish_test();
  end

  // Whole run needs about 420 cycles
  initial begin
    #(25 * 20000);
    num_errors++;
    finish_test();
  end
endmodule // rail_strobe_assignment_tb
